/* File: maf_pkg.sv */
package maf_pkg;
  // Data path widths
  localparam int unsigned DW        = 24;       // Reading width, two's complement
  localparam int unsigned SW        = 31;       // Running sum width, covers 100 full-scale readings
  localparam int unsigned AW        = 7;        // Stack address and depth width
  localparam int unsigned NFUNC     = 3;        // Dual, amp and potential functions
  localparam int unsigned STACK_LEN = 100;      // Physical stack locations

  // Depth limits and reset settings
  localparam logic [AW-1:0] DEPTH_MIN = 7'h02;
  localparam logic [AW-1:0] DEPTH_MAX = 7'h64;
  localparam logic [AW-1:0] DEPTH_RST = 7'h0A;
  localparam logic          EN_RST    = 1'b1;
  localparam logic          TYPE_MOV  = 1'b0;   // Only legal filter type code

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_OUT  = 8'h08;
  localparam logic [7:0] OFS_CFG0 = 8'h10;
  localparam logic [7:0] OFS_CFG1 = 8'h14;
  localparam logic [7:0] OFS_CFG2 = 8'h18;

  // Field positions
  localparam int unsigned CFG_DEPTH_LSB = 0;
  localparam int unsigned CFG_EN_BIT    = 8;
  localparam int unsigned CFG_TYPE_BIT  = 12;
  localparam int unsigned CFG_WIN_LSB   = 16;
  localparam int unsigned WINW          = 14;   // Window in hundredths of a percent
  localparam int unsigned STAT_ST_LSB   = 0;
  localparam int unsigned STAT_PRIM_BIT = 3;
  localparam int unsigned STAT_TRUE_BIT = 4;
  localparam int unsigned STAT_CNT_LSB  = 8;
  localparam int unsigned DIV_STEPS     = 31;

  // Window codes and their values in hundredths of a percent
  localparam logic [2:0] WIN_0P01 = 3'h0;
  localparam logic [2:0] WIN_0P1  = 3'h1;
  localparam logic [2:0] WIN_1    = 3'h2;
  localparam logic [2:0] WIN_10   = 3'h3;
  localparam logic [2:0] WIN_100  = 3'h4;
  localparam logic [2:0] WIN_RST  = WIN_0P1;
  localparam logic [WINW-1:0] PCT_0P01 = 14'h0001;
  localparam logic [WINW-1:0] PCT_0P1  = 14'h000A;
  localparam logic [WINW-1:0] PCT_1    = 14'h0064;
  localparam logic [WINW-1:0] PCT_10   = 14'h03E8;
  localparam logic [WINW-1:0] PCT_100  = 14'h2710;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FILL = 2'b01,
    ST_SUM  = 2'b10,
    ST_DIV  = 2'b11
  } maf_state_t;

  typedef struct packed {
    logic [AW-1:0] depth;
    logic          en;
    logic [2:0]    win;
  } maf_cfg_t;

  typedef struct packed {
    logic          valid;
    logic [DW-1:0] data;
  } maf_smp_t;

  // Round a window request up to the next legal step, a request above 100 percent down to 100 percent
  function automatic logic [2:0] win_round(input logic [WINW-1:0] req);
    if (req <= PCT_0P01) return WIN_0P01;
    else if (req <= PCT_0P1) return WIN_0P1;
    else if (req <= PCT_1) return WIN_1;
    else if (req <= PCT_10) return WIN_10;
    else return WIN_100;
  endfunction

  function automatic logic [WINW-1:0] win_pct(input logic [2:0] code);
    case (code)
      WIN_0P01: return PCT_0P01;
      WIN_0P1:  return PCT_0P1;
      WIN_1:    return PCT_1;
      WIN_10:   return PCT_10;
      default:  return PCT_100;
    endcase
  endfunction
endpackage

/* File: maf_stack.sv */
`timescale 1ns/100ps
// Reading stack, one write and one registered read per cycle
module maf_stack (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     wr_en,
  input  wire logic [maf_pkg::AW-1:0]   wr_addr,
  input  wire logic [maf_pkg::DW-1:0]   wr_data,
  input  wire logic                     rd_en,
  input  wire logic [maf_pkg::AW-1:0]   rd_addr,
  output logic      [maf_pkg::DW-1:0]   rd_data
);
  typedef struct packed {
    logic [maf_pkg::STACK_LEN-1:0][maf_pkg::DW-1:0] mem;
    logic [maf_pkg::DW-1:0]                         rdata;
  } maf_stk_st_t;

  maf_stk_st_t r;
  maf_stk_st_t n;

  // Read sees the old word when both ports hit one address
  always_comb begin
    n = r;
    if (rd_en) begin
      n.rdata = r.mem[rd_addr];
    end
    if (wr_en) begin
      n.mem[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign rd_data = r.rdata;
endmodule

/* File: maf_div.sv */
`timescale 1ns/100ps
// Unsigned restoring divider, one quotient bit per cycle
module maf_div (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     start,
  input  wire logic [maf_pkg::SW-1:0]   dividend,
  input  wire logic [maf_pkg::AW-1:0]   divisor,
  output logic      [maf_pkg::SW-1:0]   quot,
  output logic                          done
);
  typedef struct packed {
    logic                   busy;
    logic [4:0]             cnt;
    logic [maf_pkg::AW:0]   rem;
    logic [maf_pkg::SW-1:0] q;
    logic [maf_pkg::AW-1:0] dvs;
    logic                   done;
  } maf_div_st_t;

  maf_div_st_t r;
  maf_div_st_t n;
  logic [maf_pkg::AW:0] t;

  // Shift-subtract step; remainder never exceeds twice the divisor
  always_comb begin
    n = r;
    t = {r.rem[maf_pkg::AW-1:0], r.q[maf_pkg::SW-1]};
    n.done = 1'b0;
    if (start) begin
      n.busy = 1'b1;
      n.cnt  = 5'h00;
      n.rem  = '0;
      n.q    = dividend;
      n.dvs  = divisor;
    end else if (r.busy) begin
      n.q = {r.q[maf_pkg::SW-2:0], 1'b0};
      if (t >= {1'b0, r.dvs}) begin
        n.rem  = t - {1'b0, r.dvs};
        n.q[0] = 1'b1;
      end else begin
        n.rem = t;
      end
      n.cnt = r.cnt + 5'h01;
      if (r.cnt == 5'(maf_pkg::DIV_STEPS - 1)) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign quot = r.q;
  assign done = r.done;
endmodule

/* File: maf_top.sv */
`timescale 1ns/100ps
module maf_top (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire maf_pkg::maf_smp_t   smp_in,
  output logic                     smp_ready,
  output maf_pkg::maf_smp_t        res_out,
  output logic                     res_true
);
  typedef struct packed {
    maf_pkg::maf_state_t                     st;
    logic [1:0]                              func;
    maf_pkg::maf_cfg_t [maf_pkg::NFUNC-1:0]  cfg;
    logic                                    primed;
    logic [maf_pkg::AW-1:0]                  dep;
    logic [maf_pkg::AW-1:0]                  ptr;
    logic [maf_pkg::AW-1:0]                  cnt;
    logic [maf_pkg::AW-1:0]                  fresh;
    logic [maf_pkg::SW-1:0]                  sum;
    logic [maf_pkg::DW-1:0]                  newv;
    logic [maf_pkg::DW-1:0]                  avg;
    logic                                    neg;
    logic                                    pready;
    logic                                    pslverr;
    logic [31:0]                             prdata;
    logic                                    smp_ready;
    maf_pkg::maf_smp_t                       res;
    logic                                    res_true;
  } maf_top_st_t;

  maf_top_st_t r;
  maf_top_st_t n;

  // Stack and divider hookup
  logic                   mem_we;
  logic [maf_pkg::AW-1:0] mem_wa;
  logic [maf_pkg::DW-1:0] mem_wd;
  logic                   mem_re;
  logic [maf_pkg::AW-1:0] mem_ra;
  logic [maf_pkg::DW-1:0] mem_rd;
  logic                   div_go;
  logic [maf_pkg::SW-1:0] div_dvd;
  logic [maf_pkg::SW-1:0] div_q;
  logic                   div_done;

  // Scratch values of the combinational process
  maf_pkg::maf_cfg_t      acfg;
  maf_pkg::maf_cfg_t      wcfg;
  logic [maf_pkg::DW:0]   diff;
  logic [maf_pkg::DW:0]   adiff;
  logic [maf_pkg::DW-1:0] aavg;
  logic [39:0]            lhs;
  logic [39:0]            rhs;
  logic                   exceed;
  logic [maf_pkg::SW-1:0] prod;
  logic [maf_pkg::SW-1:0] nsum;
  logic [maf_pkg::DW-1:0] qs;
  logic                   take;
  logic                   acc;
  logic                   wr;
  logic                   hit;
  logic [31:0]            rd;
  logic                   restart;
  logic [maf_pkg::AW-1:0] wdep;

  maf_stack u_stack (
    .clk     (clk),
    .resetn  (resetn),
    .wr_en   (mem_we),
    .wr_addr (mem_wa),
    .wr_data (mem_wd),
    .rd_en   (mem_re),
    .rd_addr (mem_ra),
    .rd_data (mem_rd)
  );

  maf_div u_div (
    .clk      (clk),
    .resetn   (resetn),
    .start    (div_go),
    .dividend (div_dvd),
    .divisor  (r.dep),
    .quot     (div_q),
    .done     (div_done)
  );

  // Sign extension of a reading to sum width
  function automatic logic [maf_pkg::SW-1:0] sx(input logic [maf_pkg::DW-1:0] v);
    return {{(maf_pkg::SW - maf_pkg::DW){v[maf_pkg::DW-1]}}, v};
  endfunction

  // Register image of one function's settings
  function automatic logic [31:0] cfg_word(input maf_pkg::maf_cfg_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[maf_pkg::CFG_DEPTH_LSB +: maf_pkg::AW] = c.depth;
    w[maf_pkg::CFG_EN_BIT]                   = c.en;
    w[maf_pkg::CFG_TYPE_BIT]                 = maf_pkg::TYPE_MOV;
    w[maf_pkg::CFG_WIN_LSB +: maf_pkg::WINW] = maf_pkg::win_pct(c.win);
    return w;
  endfunction

  // Window test, done on the raw sample so no extra cycle is spent
  always_comb begin
    acfg   = r.cfg[r.func];
    diff   = {smp_in.data[maf_pkg::DW-1], smp_in.data} - {r.avg[maf_pkg::DW-1], r.avg};
    adiff  = diff[maf_pkg::DW] ? (~diff + 25'h0000001) : diff;
    aavg   = r.avg[maf_pkg::DW-1] ? (~r.avg + 24'h000001) : r.avg;
    // Cross-multiplied so no divide is needed per sample
    lhs    = 40'(adiff) * 40'(maf_pkg::PCT_100);
    rhs    = 40'(aavg) * 40'(maf_pkg::win_pct(acfg.win));
    exceed = lhs > rhs;
    prod   = sx(smp_in.data) * {24'h000000, acfg.depth};
    nsum   = r.sum - sx(mem_rd) + sx(r.newv);
    qs     = div_q[maf_pkg::DW-1:0];
  end

  // Filter sequencer and register file
  always_comb begin
    n           = r;
    n.res.valid = 1'b0;
    mem_we      = 1'b0;
    mem_wa      = r.cnt;
    mem_wd      = r.newv;
    mem_re      = 1'b0;
    mem_ra      = r.ptr;
    div_go      = 1'b0;
    div_dvd     = nsum[maf_pkg::SW-1] ? (~nsum + 31'h00000001) : nsum;
    take        = smp_in.valid & r.smp_ready;
    restart     = 1'b0;
    wcfg        = '0;
    wdep        = '0;

    case (r.st)
      maf_pkg::ST_IDLE: begin
        if (take) begin
          if (!acfg.en) begin
            // Raw pass-through, next enable starts from an empty stack
            n.res.valid = 1'b1;
            n.res.data  = smp_in.data;
            n.res_true  = 1'b0;
            n.primed    = 1'b0;
          end else if (!r.primed || exceed) begin
            n.newv      = smp_in.data;
            n.dep       = acfg.depth;
            n.sum       = prod;
            n.cnt       = '0;
            n.smp_ready = 1'b0;
            n.st        = maf_pkg::ST_FILL;
          end else begin
            // Fetch the oldest entry that this reading replaces
            mem_re      = 1'b1;
            mem_ra      = r.ptr;
            n.newv      = smp_in.data;
            n.smp_ready = 1'b0;
            n.st        = maf_pkg::ST_SUM;
          end
        end
      end

      maf_pkg::ST_FILL: begin
        // Copy the first reading into every location of the active depth
        mem_we = 1'b1;
        mem_wa = r.cnt;
        mem_wd = r.newv;
        if (r.cnt == 7'(r.dep - 7'h01)) begin
          n.ptr       = '0;
          n.fresh     = '0;
          n.primed    = 1'b1;
          n.avg       = r.newv;
          n.res.valid = 1'b1;
          n.res.data  = r.newv;
          n.res_true  = 1'b0;
          n.smp_ready = 1'b1;
          n.st        = maf_pkg::ST_IDLE;
        end else begin
          n.cnt = 7'(r.cnt + 7'h01);
        end
      end

      maf_pkg::ST_SUM: begin
        // Oldest out, newest in, pointer wraps at the programmed depth
        mem_we = 1'b1;
        mem_wa = r.ptr;
        mem_wd = r.newv;
        n.ptr  = (r.ptr == 7'(r.dep - 7'h01)) ? 7'h00 : 7'(r.ptr + 7'h01);
        if (r.fresh < r.dep) begin
          n.fresh = 7'(r.fresh + 7'h01);
        end
        n.sum  = nsum;
        n.neg  = nsum[maf_pkg::SW-1];
        div_go = 1'b1;
        n.st   = maf_pkg::ST_DIV;
      end

      maf_pkg::ST_DIV: begin
        // Quotient truncates toward zero, sign applied afterwards
        if (div_done) begin
          n.avg       = r.neg ? (~qs + 24'h000001) : qs;
          n.res.valid = 1'b1;
          n.res.data  = r.neg ? (~qs + 24'h000001) : qs;
          n.res_true  = (r.fresh >= r.dep);
          n.smp_ready = 1'b1;
          n.st        = maf_pkg::ST_IDLE;
        end
      end

      default: begin
        n.st = maf_pkg::ST_IDLE;
      end
    endcase

    // APB: one wait state, data and error registered with pready
    acc       = psel & penable & ~r.pready;
    wr        = psel & penable & r.pready & pwrite & ~r.pslverr;
    n.pready  = acc;
    rd        = 32'h0000_0000;
    hit       = 1'b1;
    if (paddr == maf_pkg::OFS_CTRL) begin
      rd = {30'h0000_0000, r.func};
    end else if (paddr == maf_pkg::OFS_STAT) begin
      rd[maf_pkg::STAT_ST_LSB +: 2]           = r.st;
      rd[maf_pkg::STAT_PRIM_BIT]              = r.primed;
      rd[maf_pkg::STAT_TRUE_BIT]              = r.res_true;
      rd[maf_pkg::STAT_CNT_LSB +: maf_pkg::AW] = r.fresh;
    end else if (paddr == maf_pkg::OFS_OUT) begin
      rd = {{(32 - maf_pkg::DW){r.avg[maf_pkg::DW-1]}}, r.avg};
    end else if (paddr == maf_pkg::OFS_CFG0) begin
      rd = cfg_word(r.cfg[0]);
    end else if (paddr == maf_pkg::OFS_CFG1) begin
      rd = cfg_word(r.cfg[1]);
    end else if (paddr == maf_pkg::OFS_CFG2) begin
      rd = cfg_word(r.cfg[2]);
    end else begin
      hit = 1'b0;
    end
    if (acc) begin
      n.prdata  = pwrite ? 32'h0000_0000 : rd;
      n.pslverr = ~hit;
    end else begin
      n.prdata  = 32'h0000_0000;
      n.pslverr = 1'b0;
    end

    // Settings decode; a write shaping the active function restarts it
    wdep = pwdata[maf_pkg::CFG_DEPTH_LSB +: maf_pkg::AW];
    if (wdep < maf_pkg::DEPTH_MIN) begin
      wcfg.depth = maf_pkg::DEPTH_MIN;
    end else if (wdep > maf_pkg::DEPTH_MAX) begin
      wcfg.depth = maf_pkg::DEPTH_MAX;
    end else begin
      wcfg.depth = wdep;
    end
    wcfg.en  = pwdata[maf_pkg::CFG_EN_BIT];
    // Type bit is not stored, moving average is always in force
    wcfg.win = maf_pkg::win_round(pwdata[maf_pkg::CFG_WIN_LSB +: maf_pkg::WINW]);
    if (wr) begin
      if (paddr == maf_pkg::OFS_CTRL) begin
        if (pwdata[1:0] < 2'(maf_pkg::NFUNC) && pwdata[1:0] != r.func) begin
          n.func  = pwdata[1:0];
          restart = 1'b1;
        end
      end else if (paddr == maf_pkg::OFS_CFG0) begin
        n.cfg[0] = wcfg;
        restart  = (r.func == 2'h0);
      end else if (paddr == maf_pkg::OFS_CFG1) begin
        n.cfg[1] = wcfg;
        restart  = (r.func == 2'h1);
      end else if (paddr == maf_pkg::OFS_CFG2) begin
        n.cfg[2] = wcfg;
        restart  = (r.func == 2'h2);
      end
    end
    // Restart wins over a fill that completes in the same cycle
    if (restart) begin
      n.primed = 1'b0;
      n.fresh  = '0;
    end
  end

  // State register; reset loads the documented default settings
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r           <= '0;
      r.st        <= maf_pkg::ST_IDLE;
      r.smp_ready <= 1'b1;
      for (int i = 0; i < maf_pkg::NFUNC; i++) begin
        r.cfg[i].depth <= maf_pkg::DEPTH_RST;
        r.cfg[i].en    <= maf_pkg::EN_RST;
        r.cfg[i].win   <= maf_pkg::WIN_RST;
      end
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign prdata    = r.prdata;
  assign pready    = r.pready;
  assign pslverr   = r.pslverr;
  assign smp_ready = r.smp_ready;
  assign res_out   = r.res;
  assign res_true  = r.res_true;
endmodule

/* File: maf_assertions.sv */
`timescale 1ns/100ps
// Port-level checks of the bus answer and the result stream
module maf_assertions (
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire maf_pkg::maf_smp_t smp_in,
  input wire logic              smp_ready,
  input wire maf_pkg::maf_smp_t res_out,
  input wire logic              res_true
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Decoded word offsets, anything else must be refused
  logic mapped;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18};

  sequence s_first_access;
    psel && penable && $rose(penable);
  endsequence
  sequence s_take;
    smp_in.valid && smp_ready;
  endsequence

  property p_wait; s_first_access |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pready && !mapped |-> pslverr; endproperty
  property p_ok; pready && mapped |-> !pslverr; endproperty
  property p_errz; pslverr |-> prdata == 32'h0; endproperty
  property p_res_pulse; res_out.valid |=> !res_out.valid; endproperty
  property p_res_ready; res_out.valid |-> smp_ready; endproperty
  property p_bound; s_take ##1 !smp_ready |-> ##[0:100] res_out.valid; endproperty
  property p_true_upd; $changed(res_true) |-> res_out.valid; endproperty

  a_wait: assert property (p_wait) else $error("pready not one cycle after access");
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  a_err: assert property (p_err) else $error("unmapped access without pslverr");
  a_ok: assert property (p_ok) else $error("mapped access with pslverr");
  a_errz: assert property (p_errz) else $error("refused access with nonzero data");
  a_res_pulse: assert property (p_res_pulse) else $error("result valid too long");
  a_res_ready: assert property (p_res_ready) else $error("result without ready");
  a_bound: assert property (p_bound) else $error("result late after take");
  a_true_upd: assert property (p_true_upd) else $error("true flag moved alone");
endmodule

bind maf_top maf_assertions u_maf_assertions (.clk(clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .smp_in(smp_in), .smp_ready(smp_ready),
  .res_out(res_out), .res_true(res_true));

/* File: maf_front_model.sv */
`timescale 1ns/100ps
// Front end model: holds each reading until the filter takes it
module maf_front_model (
  input  wire logic          clk,
  input  wire logic          smp_ready,
  output maf_pkg::maf_smp_t  smp
);
  initial smp = '{1'b0, 24'h5A5A5A};

  // Optional stall first, so both prompt and slow sources are seen
  task automatic send(input logic [23:0] x, input int stall);
    repeat (stall) @(posedge clk);
    smp <= '{1'b1, x};
    // No local limit, the bench watchdog ends a hang
    do begin
      @(posedge clk);
    end while (smp_ready !== 1'b1);
    smp <= '{1'b0, ~x}; // Released data no longer shows the reading
  endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/100ps
// Self-checking bench for the moving-average filter
module tb_top;
  logic              clk;
  logic              resetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic              pready;
  logic              pslverr;
  logic              err;
  logic              smp_ready;
  logic              res_true;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic [31:0]       rd;
  maf_pkg::maf_smp_t smp_in;
  maf_pkg::maf_smp_t res_out;
  int                errors = 0;
  int                n_tests = 0;
  int                cyc = 0;
  int                ptr;
  int                stk [100];
  int                wins [13] = '{0, 1, 2, 10, 11, 50, 100, 101, 1000, 1001, 10000, 10001, 16383};
  int                deps [6] = '{0, 1, 2, 100, 101, 127};

  maf_top u_maf_top (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .smp_in(smp_in), .smp_ready(smp_ready), .res_out(res_out), .res_true(res_true));
  maf_front_model u_maf_front_model (.clk(clk), .smp_ready(smp_ready), .smp(smp_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim;
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; an idle edge after it keeps drivers single per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] cfg_word(input int d, input int e, input int w, input int t);
    return {2'b00, w[13:0], 3'b000, t[0], 3'b000, e[0], 1'b0, d[6:0]};
  endfunction

  // Window request rounded up to one of five steps, anything above the top step taken as the top step, depth clamped
  function automatic int win_exp(input int r);
    if (r <= 1) return 1;
    if (r <= 10) return 10;
    if (r <= 100) return 100;
    if (r <= 1000) return 1000;
    return 10000;
  endfunction

  function automatic int clamp(input int d);
    return (d < 2) ? 2 : (d > 100) ? 100 : d;
  endfunction

  function automatic int mean(input int d);
    int s;
    s = 0;
    for (int i = 0; i < d; i++) s += stk[i];
    return s / d;
  endfunction

  // Hand one reading over and check the single result it yields
  task automatic take(input int x, input int ed, input logic et, input logic ct);
    u_maf_front_model.send(x[23:0], $urandom_range(3));
    do begin
      @(posedge clk);
    end while (res_out.valid !== 1'b1);
    chk("res_data", {8'h00, res_out.data}, {8'h00, ed[23:0]});
    if (ct) chk("res_true", {31'h0, res_true}, {31'h0, et});
  endtask

  task automatic run_filter(input int f, input int d);
    int x;
    int avg;
    apb(1'b1, 8'h00, f);
    apb(1'b1, 8'(8'h10 + 4 * f), cfg_word(d, 1, 10000, 0));
    x = 1000 + $urandom_range(100000);
    for (int i = 0; i < d; i++) stk[i] = x;
    ptr = 0;
    take(x, x, 1'b0, 1'b1);
    avg = x;
    for (int k = 1; k <= d + 2; k++) begin
      x = avg + $urandom_range(avg / 2);
      stk[ptr] = x;
      ptr = (ptr + 1) % d;
      avg = mean(d);
      take(x, avg, k >= d, 1'b1);
    end
    x = -3 * avg;
    take(x, x, 1'b0, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    chk("out_reg", rd, x);
  endtask

  // Hang guard, far above the longest expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_sim;
    end
  end

  initial begin
    int d;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(48457));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int f = 0; f < 3; f++) begin
      apb(1'b0, 8'(8'h10 + 4 * f), 32'h0);
      chk("cfg_reset", rd, cfg_word(10, 1, 10, 0));
    end
    apb(1'b0, 8'h04, 32'h0);
    chk("stat_reset", rd, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    // Window table with edge depths first, then random depths
    for (int i = 0; i < 13; i++) begin
      d = (i < 6) ? deps[i] : $urandom_range(127);
      apb(1'b1, 8'h18, cfg_word(d, i % 2, wins[i], 1));
      apb(1'b0, 8'h18, 32'h0);
      chk("cfg_fields", rd, cfg_word(clamp(d), i % 2, win_exp(wins[i]), 0));
    end
    apb(1'b0, 8'h14, 32'h0);
    chk("cfg_other", rd, cfg_word(10, 1, 10, 0));
    run_filter(0, 2);
    run_filter(1, 5);
    run_filter(2, 100);
    apb(1'b1, 8'h18, cfg_word(4, 0, 10, 0));
    d = -$urandom_range(5000);
    take(d, d, 1'b0, 1'b1);
    take(4321, 4321, 1'b0, 1'b1);
    end_sim;
  end
endmodule
